// ---- core/tme_map.svh ----
// Trigger mask engine: register offsets, field bits and commands.
// Assumes inclusion by the package, the engine and the bench, by bare name.
`ifndef TME_MAP_SVH
`define TME_MAP_SVH

// Register bus widths
`define TME_AW 16
`define TME_DW 32

// Register offsets
`define TME_OFS_CMD 16'h0064
`define TME_OFS_TOUT 16'h9ca4
`define TME_OFS_GOR 16'h9dda
`define TME_OFS_GAV 16'h9de4
`define TME_OFS_GAND 16'h9dee
`define TME_OFS_CAV_LO 16'h9e16
`define TME_OFS_CAV_HI 16'h9e17
`define TME_OFS_CAND_LO 16'h9e20
`define TME_OFS_CAND_HI 16'h9e21

// General mask source bits
`define TME_BIT_SW 0
`define TME_BIT_EXT0 1
`define TME_BIT_EXT1 2
`define TME_BIT_EXTRA_TTL_INPUT_ZERO 8
`define TME_BIT_EXTRA_TTL_INPUT_ONE 9

// Mask values
`define TME_NO_SOURCE 32'h0000_0000
`define TME_GOR_RST 32'h0000_0001
`define TME_GAND_AVAIL 32'h0000_0306
`define TME_GOR_AVAIL 32'h0000_0307
`define TME_CH_AVAIL 32'hffff_ffff

// Command bits
`define TME_CMD_ARM 3
`define TME_CMD_FORCE 4
`define TME_CMD_DISARM 5

// Trigger output control bit
`define TME_TOUT_EN 0

`endif

// ---- core/tme_pkg.sv ----
// Trigger mask engine types: bus carriers, states, state record.
// Assumes tme_map.svh is on the include path.
`include "tme_map.svh"

package tme_pkg;

  // Register port request from software
  typedef struct packed {
    logic [`TME_AW-1:0] addr;
    logic [`TME_DW-1:0] wdata;
    logic wr;
    logic rd;
  } tme_bus_s;

  // Engine states, Gray coded from IDLE through PRE and WAIT to RUN
  typedef enum logic [1:0] {
    TME_IDLE = 2'h0,
    TME_PRE = 2'h1,
    TME_WAIT = 2'h3,
    TME_RUN = 2'h2
  } tme_state_e;

  // Whole state of the engine
  typedef struct packed {
    tme_state_e st;
    logic armed;
    logic [`TME_DW-1:0] gand;
    logic [`TME_DW-1:0] cand_lo;
    logic [`TME_DW-1:0] cand_hi;
    logic [`TME_DW-1:0] gor;
    logic tout;
    logic [`TME_DW-1:0] rdata;
    logic trig;
    logic pin_o;
    logic pin_oe;
    logic [2:0] sync1;
    logic [2:0] sync2;
  } tme_reg_s;

endpackage

// ---- core/tme_engine.sv ----
// Trigger combination engine: AND/OR masks, arm, force, trigger out.
// Assumes channel detectors and sequencer signals share i_mclk;
// the trigger connector and extra TTL pins arrive asynchronously.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tme_map.svh"

module tme_engine #(
  parameter logic [`TME_DW-1:0] GAND_AVAIL = `TME_GAND_AVAIL,
  parameter logic [`TME_DW-1:0] GOR_AVAIL = `TME_GOR_AVAIL,
  parameter logic [`TME_DW-1:0] CH_AVAIL_LO = `TME_CH_AVAIL,
  parameter logic [`TME_DW-1:0] CH_AVAIL_HI = `TME_CH_AVAIL
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire tme_pkg::tme_bus_s i_bus,
  input wire logic i_card_start,
  input wire logic i_pre_done,
  input wire logic i_acq_done,
  input wire logic [`TME_DW-1:0] i_ch_lo,
  input wire logic [`TME_DW-1:0] i_ch_hi,
  input wire logic i_trig_pin,
  input wire logic [1:0] i_xio,
  input wire logic i_ext1,
  output logic [`TME_DW-1:0] o_rdata,
  output logic o_trig,
  output logic o_armed,
  output logic o_trig_pin,
  output logic o_trig_pin_oe
);
  import tme_pkg::*;

  tme_reg_s r_ff;
  tme_reg_s nxt_r;

  // Conditions seen by the masks
  logic [`TME_DW-1:0] gen_cond;
  logic [`TME_DW-1:0] gand_en;
  logic [`TME_DW-1:0] cand_lo_en;
  logic [`TME_DW-1:0] cand_hi_en;
  logic [`TME_DW-1:0] gor_en;
  logic and_any;
  logic and_hit;
  logic or_hit;
  logic waiting;
  logic wr_cmd;
  logic force_hit;
  logic cmd_arm;
  logic cmd_disarm;
  logic fire;
  logic ext0_used;

  // True when every enabled source meets its condition
  function automatic logic all_met(
    input logic [`TME_DW-1:0] en,
    input logic [`TME_DW-1:0] cond
  );
    all_met = &(~en | cond);
  endfunction

  // Write strobe decode for one offset
  function automatic logic wr_at(
    input tme_bus_s b,
    input logic [`TME_AW-1:0] ofs
  );
    wr_at = b.wr && (b.addr == ofs);
  endfunction

  // Synchronised pins except ext1, which is used as is: ext0 shares the connector
  always_comb begin
    gen_cond = `TME_NO_SOURCE;
    gen_cond[`TME_BIT_SW] = 1'b1;
    gen_cond[`TME_BIT_EXT0] = r_ff.sync2[0];
    gen_cond[`TME_BIT_EXT1] = i_ext1;
    gen_cond[`TME_BIT_EXTRA_TTL_INPUT_ZERO] = r_ff.sync2[1];
    gen_cond[`TME_BIT_EXTRA_TTL_INPUT_ONE] = r_ff.sync2[2];
  end

  // AND combination over both mask parts
  always_comb begin
    gand_en = r_ff.gand & GAND_AVAIL;
    gand_en[`TME_BIT_SW] = 1'b0;
    cand_lo_en = r_ff.cand_lo & CH_AVAIL_LO;
    cand_hi_en = r_ff.cand_hi & CH_AVAIL_HI;
    and_any = (|gand_en) | (|cand_lo_en) | (|cand_hi_en);
    // No enabled source must not read as a hit
    and_hit = and_any
      && all_met(gand_en, gen_cond)
      && all_met(cand_lo_en, i_ch_lo)
      && all_met(cand_hi_en, i_ch_hi);
  end

  // OR combination, software bit always true
  always_comb begin
    gor_en = r_ff.gor & GOR_AVAIL;
    or_hit = |(gor_en & gen_cond);
  end

  // Command decode and trigger decision
  always_comb begin
    waiting = (r_ff.st == TME_WAIT);
    wr_cmd = wr_at(i_bus, `TME_OFS_CMD);
    cmd_arm = wr_cmd && i_bus.wdata[`TME_CMD_ARM];
    cmd_disarm = wr_cmd && i_bus.wdata[`TME_CMD_DISARM];
    // Ignored unless waiting: no queued force
    force_hit = wr_cmd && i_bus.wdata[`TME_CMD_FORCE] && waiting;
    // Armed gates sources, never force
    fire = waiting && (force_hit || (r_ff.armed && (and_hit || or_hit)));
    // Connector turns input when ext0 is in a mask
    ext0_used = r_ff.gor[`TME_BIT_EXT0] || r_ff.gand[`TME_BIT_EXT0];
  end

  // Next state of the whole engine
  always_comb begin
    nxt_r = r_ff;
    nxt_r.sync1 = {i_xio, i_trig_pin};
    nxt_r.sync2 = r_ff.sync1;

    // Masks: a write replaces the whole OR-ed bit set
    if (wr_at(i_bus, `TME_OFS_GAND)) begin
      nxt_r.gand = i_bus.wdata & GAND_AVAIL;
    end
    if (wr_at(i_bus, `TME_OFS_CAND_LO)) begin
      nxt_r.cand_lo = i_bus.wdata;
    end
    if (wr_at(i_bus, `TME_OFS_CAND_HI)) begin
      nxt_r.cand_hi = i_bus.wdata;
    end
    if (wr_at(i_bus, `TME_OFS_GOR)) begin
      nxt_r.gor = i_bus.wdata & GOR_AVAIL;
    end
    if (wr_at(i_bus, `TME_OFS_TOUT)) begin
      nxt_r.tout = i_bus.wdata[`TME_TOUT_EN];
    end

    // Disarm wins if both bits come in one write
    if (cmd_disarm) begin
      nxt_r.armed = 1'b0;
    end else if (cmd_arm) begin
      nxt_r.armed = 1'b1;
    end

    // Sequencer: start, pretrigger fill, wait, record
    case (r_ff.st)
      TME_IDLE: begin
        if (i_card_start) begin
          nxt_r.st = TME_PRE;
        end
      end
      TME_PRE: begin
        // Software trigger waits for pretrigger fill
        if (i_pre_done) begin
          nxt_r.st = TME_WAIT;
        end
      end
      TME_WAIT: begin
        // Leaving WAIT makes each force a single event
        if (fire) begin
          nxt_r.st = TME_RUN;
        end
      end
      TME_RUN: begin
        // Masks untouched by force, so wait resumes as set
        if (i_acq_done) begin
          nxt_r.st = TME_PRE;
        end
      end
      default: begin
        nxt_r.st = TME_IDLE;
      end
    endcase
    if (!i_card_start) begin
      nxt_r.st = TME_IDLE;
    end

    // Event pulse and connector drive
    nxt_r.trig = fire;
    nxt_r.pin_oe = r_ff.tout && !ext0_used;
    nxt_r.pin_o = fire && r_ff.tout && !ext0_used;

    // Read data, valid only in the cycle after the strobe
    nxt_r.rdata = `TME_NO_SOURCE;
    if (i_bus.rd) begin
      case (i_bus.addr)
        `TME_OFS_TOUT: nxt_r.rdata[`TME_TOUT_EN] = r_ff.tout;
        `TME_OFS_GOR: nxt_r.rdata = r_ff.gor;
        `TME_OFS_GAV: nxt_r.rdata = GAND_AVAIL;
        `TME_OFS_GAND: nxt_r.rdata = r_ff.gand;
        `TME_OFS_CAV_LO: nxt_r.rdata = CH_AVAIL_LO;
        `TME_OFS_CAV_HI: nxt_r.rdata = CH_AVAIL_HI;
        `TME_OFS_CAND_LO: nxt_r.rdata = r_ff.cand_lo;
        `TME_OFS_CAND_HI: nxt_r.rdata = r_ff.cand_hi;
        default: nxt_r.rdata = `TME_NO_SOURCE;
      endcase
    end
  end

  // State register; reset constants only
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      r_ff <= '0;
      r_ff.st <= TME_IDLE;
      r_ff.armed <= 1'b0;
      r_ff.gor <= `TME_GOR_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Outputs come straight from flops
  assign o_rdata = r_ff.rdata;
  assign o_trig = r_ff.trig;
  assign o_armed = r_ff.armed;
  assign o_trig_pin = r_ff.pin_o;
  assign o_trig_pin_oe = r_ff.pin_oe;

  default clocking tme_cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  // Software-only AND mask value with no channel must never hit
  chk_and_no_sw: assert property (
    ((r_ff.gand & ~`TME_GOR_RST) == `TME_NO_SOURCE && !(|cand_lo_en) && !(|cand_hi_en))
      |-> !and_hit)
    else $error("software bit took part in AND");

  chk_and_empty: assert property (
    (waiting && !and_any && !or_hit && !force_hit) |=> !o_trig)
    else $error("AND fired with no source enabled");

  chk_sw_fire: assert property (
    (waiting && r_ff.armed && gor_en[`TME_BIT_SW]) |=> o_trig)
    else $error("software trigger did not fire");

  chk_force_idle: assert property (
    (wr_cmd && i_bus.wdata[`TME_CMD_FORCE] && !waiting) |=> !o_trig)
    else $error("trigger outside waiting state");

  chk_force_once: assert property (
    o_trig |-> !$past(o_trig) ##1 !o_trig)
    else $error("force gave more than one event");

  chk_disarm_quiet: assert property (
    (waiting && !r_ff.armed && !force_hit) |=> !o_trig)
    else $error("trigger while disarmed");

  chk_force_disarm: assert property (
    (force_hit && !r_ff.armed) |=> o_trig ##1 (r_ff.st == TME_RUN))
    else $error("force ignored while disarmed");

  chk_arm_cmd: assert property (
    (cmd_arm && !cmd_disarm) |=> o_armed)
    else $error("arm command not taken");

  chk_pin_pulse: assert property (
    o_trig_pin |-> (o_trig && o_trig_pin_oe))
    else $error("trigger out pulse without event");

  chk_out_off: assert property (
    (!r_ff.tout) |=> !o_trig_pin_oe)
    else $error("connector driven while disabled");

  chk_pre_first: assert property (
    (r_ff.st == TME_PRE) |=> !o_trig)
    else $error("trigger before pretrigger fill");

  // Force and sequencer checks
  chk_force_fire: assert property (
    force_hit |=> o_trig)
    else $error("force while waiting gave no event");

  chk_force_leave: assert property (
    force_hit |=> !waiting)
    else $error("engine still waiting after force");

  chk_run_quiet: assert property (
    (r_ff.st == TME_RUN) |=> !o_trig)
    else $error("second event during recording");

  chk_idle_quiet: assert property (
    (r_ff.st == TME_IDLE) |=> !o_trig)
    else $error("trigger before card start");

  chk_trig_cause: assert property (
    o_trig |-> $past(waiting))
    else $error("trigger not decided in waiting state");

  // Source combination checks
  chk_and_fire: assert property (
    (waiting && r_ff.armed && and_hit) |=> o_trig)
    else $error("AND hit gave no event");

  chk_ext0_or: assert property (
    (waiting && r_ff.armed && gor_en[`TME_BIT_EXT0] && r_ff.sync2[0]) |=> o_trig)
    else $error("ext input zero in OR gave no event");

  chk_gand_ext0: assert property (
    (gand_en[`TME_BIT_EXT0] && !r_ff.sync2[0]) |-> !and_hit)
    else $error("AND ignored ext input zero");

  chk_gand_ext1: assert property (
    (gand_en[`TME_BIT_EXT1] && !i_ext1) |-> !and_hit)
    else $error("AND ignored ext input one");

  chk_gand_extra_ttl_input_zero: assert property (
    (gand_en[`TME_BIT_EXTRA_TTL_INPUT_ZERO] && !r_ff.sync2[1]) |-> !and_hit)
    else $error("AND ignored extra TTL zero");

  chk_gand_extra_ttl_input_one: assert property (
    (gand_en[`TME_BIT_EXTRA_TTL_INPUT_ONE] && !r_ff.sync2[2]) |-> !and_hit)
    else $error("AND ignored extra TTL one");

  chk_chan_lo: assert property (
    (|(cand_lo_en & ~i_ch_lo)) |-> !and_hit)
    else $error("AND ignored a low channel");

  chk_chan_hi: assert property (
    (|(cand_hi_en & ~i_ch_hi)) |-> !and_hit)
    else $error("AND ignored a high channel");

  // Arm state checks
  chk_disarm_cmd: assert property (
    cmd_disarm |=> !o_armed)
    else $error("disarm command not taken");

  chk_armed_hold: assert property (
    !wr_cmd |=> $stable(o_armed))
    else $error("armed state changed without command");

  // Connector and read-back checks
  chk_pin_drive: assert property (
    (fire && r_ff.tout && !ext0_used) |=> o_trig_pin)
    else $error("trigger out pulse missing");

  chk_pin_idle: assert property (
    !fire |=> !o_trig_pin)
    else $error("trigger out high without decision");

  chk_out_on: assert property (
    (r_ff.tout && !ext0_used) |=> o_trig_pin_oe)
    else $error("connector not driven while enabled");

  chk_gav_read: assert property (
    (i_bus.rd && (i_bus.addr == `TME_OFS_GAV)) |=> (o_rdata == GAND_AVAIL))
    else $error("general AND availability misread");

  chk_cav_lo_read: assert property (
    (i_bus.rd && (i_bus.addr == `TME_OFS_CAV_LO)) |=> (o_rdata == CH_AVAIL_LO))
    else $error("low channel availability misread");

  chk_cav_hi_read: assert property (
    (i_bus.rd && (i_bus.addr == `TME_OFS_CAV_HI)) |=> (o_rdata == CH_AVAIL_HI))
    else $error("high channel availability misread");

endmodule // tme_engine
`default_nettype wire

// ---- tb/tme_seq_model.sv ----
// Sequencer partner: pretrigger fill and end of each segment.
// Assumes the engine clock and reset; start level comes from the bench.
`timescale 1ns/1ps
`default_nettype none

module tme_seq_model (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_trig,
  output logic o_pre_done,
  output logic o_acq_done
);
  logic [2:0] run_ff;

  // Pretrigger fill takes one cycle; segment end pulses three cycles after the trigger pulse
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_pre_done <= 1'b0;
      run_ff <= 3'h0;
    end else begin
      o_pre_done <= i_start;
      run_ff <= {run_ff[1:0], i_trig};
    end
  end

  // Segment end pulse re-enters pretrigger, then waiting
  assign o_acq_done = run_ff[2];
endmodule // tme_seq_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the trigger mask engine.
// Assumes the sequencer model drives pretrigger and segment end.
`timescale 1ns/1ps
`default_nettype none
`include "tme_map.svh"

module testbench;
  import tme_pkg::*;
  logic i_mclk;
  logic i_rst;
  logic card_start;
  logic trig_pin;
  logic [31:0] ch_lo;
  logic [31:0] ch_hi;
  logic [1:0] xio;
  logic ext1;
  logic [31:0] rdata;
  logic trig;
  logic armed;
  logic pin_o;
  logic pin_oe;
  logic pre_done;
  logic acq_done;
  tme_bus_s bus;
  int errors = 0;
  int tests_run = 0;
  int n;

  tme_engine u_tme_engine (.i_mclk(i_mclk), .i_rst(i_rst), .i_bus(bus),
    .i_card_start(card_start), .i_pre_done(pre_done), .i_acq_done(acq_done),
    .i_ch_lo(ch_lo), .i_ch_hi(ch_hi), .i_trig_pin(trig_pin), .i_xio(xio),
    .i_ext1(ext1), .o_rdata(rdata), .o_trig(trig), .o_armed(armed),
    .o_trig_pin(pin_o), .o_trig_pin_oe(pin_oe));

  tme_seq_model u_tme_seq_model (.i_mclk(i_mclk), .i_rst(i_rst), .i_start(card_start),
    .i_trig(trig), .o_pre_done(pre_done), .o_acq_done(acq_done));

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write; extra edge keeps strobes from merging
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    bus.wr <= 1'b0;
    @(posedge i_mclk);
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp);
    @(posedge i_mclk);
  endtask

  // Count pulses from the cycle already running; driven pin must echo them
  task automatic count_trig(input int cyc, output int c);
    c = 0;
    repeat (cyc) begin
      #1;
      if (trig === 1'b1) c++;
      if (pin_oe === 1'b1) chk({31'h0, pin_o}, {31'h0, trig});
      @(posedge i_mclk);
    end
  endtask

  // Force write counted from the edge that takes it: the pulse stands one cycle
  task automatic force_count(input int cyc, output int c);
    bus <= '{addr: `TME_OFS_CMD, wdata: 32'h10, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    bus.wr <= 1'b0;
    count_trig(cyc, c);
  endtask

  task automatic results;
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // 20 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  // Main sequence
  initial begin
    i_rst = 1'b1;
    card_start = 1'b0;
    trig_pin = 1'b0;
    ch_lo = 32'h0;
    ch_hi = 32'h0;
    xio = 2'h0;
    ext1 = 1'b0;
    bus = '0;
    repeat (4) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    chk({31'h0, armed}, 32'h0);
    rd(`TME_OFS_GOR, `TME_GOR_RST);
    rd(`TME_OFS_GAND, `TME_NO_SOURCE);
    rd(`TME_OFS_TOUT, 32'h0);
    rd(`TME_OFS_GAV, `TME_GAND_AVAIL);
    rd(`TME_OFS_CAV_LO, `TME_CH_AVAIL);
    rd(`TME_OFS_CAV_HI, `TME_CH_AVAIL);
    rd(16'h0100, 32'h0);
    wr(`TME_OFS_GAV, 32'h0);
    rd(`TME_OFS_GAV, `TME_GAND_AVAIL);
    $display("test reset done");
    // Mask layout; software bit never kept in the AND mask
    wr(`TME_OFS_GAND, 32'h0000_0307);
    rd(`TME_OFS_GAND, 32'h0000_0306);
    wr(`TME_OFS_CAND_LO, 32'h0000_0009);
    rd(`TME_OFS_CAND_LO, 32'h0000_0009);
    wr(`TME_OFS_CAND_HI, 32'h8000_0001);
    rd(`TME_OFS_CAND_HI, 32'h8000_0001);
    wr(`TME_OFS_GAND, `TME_NO_SOURCE);
    wr(`TME_OFS_CAND_HI, `TME_NO_SOURCE);
    $display("test masks done");
    // Force outside waiting leaves no trace
    wr(`TME_OFS_GOR, 32'h0000_0002);
    wr(`TME_OFS_TOUT, 32'h1);
    force_count(20, n);
    chk(n, 0);
    // Disarmed: ext input zero ignored, force still fires once
    trig_pin <= 1'b1;
    card_start <= 1'b1;
    count_trig(20, n);
    chk(n, 0);
    force_count(20, n);
    chk(n, 1);
    // Armed: programmed OR source fires again
    wr(`TME_OFS_CMD, 32'h8);
    chk({31'h0, armed}, 32'h1);
    count_trig(20, n);
    chk({31'h0, n > 0}, 32'h1);
    $display("test force done");
    // Channel AND: unrelated channel high gives nothing
    trig_pin <= 1'b0;
    wr(`TME_OFS_GOR, `TME_NO_SOURCE);
    wr(`TME_OFS_CAND_LO, 32'h0000_0008);
    ch_lo <= 32'h0000_0001;
    count_trig(20, n);
    chk(n, 0);
    ch_lo <= 32'h0000_0008;
    count_trig(20, n);
    chk({31'h0, n > 0}, 32'h1);
    ch_lo <= 32'h0;
    wr(`TME_OFS_CAND_LO, `TME_NO_SOURCE);
    // General AND over ext input one and extra TTL, with channel 63
    wr(`TME_OFS_GAND, 32'h0000_0304);
    wr(`TME_OFS_CAND_HI, 32'h8000_0000);
    xio <= 2'h3;
    ch_hi <= 32'h8000_0000;
    count_trig(20, n);
    chk(n, 0);
    ext1 <= 1'b1;
    count_trig(20, n);
    chk({31'h0, n > 0}, 32'h1);
    wr(`TME_OFS_GAND, `TME_NO_SOURCE);
    wr(`TME_OFS_CAND_HI, `TME_NO_SOURCE);
    $display("test and done");
    // Software source: blocked while disarmed, free run once armed
    wr(`TME_OFS_CMD, 32'h20);
    chk({31'h0, armed}, 32'h0);
    wr(`TME_OFS_GOR, 32'h0000_0001);
    count_trig(20, n);
    chk(n, 0);
    chk({31'h0, pin_oe}, 32'h1);
    wr(`TME_OFS_CMD, 32'h8);
    count_trig(20, n);
    chk({31'h0, n > 0}, 32'h1);
    wr(`TME_OFS_TOUT, 32'h0);
    // Enable follows the control bit one edge later
    @(posedge i_mclk);
    chk({31'h0, pin_oe}, 32'h0);
    $display("test software done");
    results();
  end
endmodule // testbench
`default_nettype wire
